// file: bench/iox_master.sv
`timescale 1ns/10ps
// ***************************************************
// bus master model
// ***************************************************
module iox_master (
    // pacing clock
    input  wire logic ref_clk,
    // resolved data wire
    input  wire logic sda_w,
    // bus clock, idle high between frames
    output logic      scl_clk,
    // high while the master pulls data low
    output logic      m_low
);
    initial
    begin
        scl_clk = 1'b1;
        m_low   = 1'b0;
    end

    // one bus phase, well above the minimum high and low times
    task automatic ph;
        repeat (8) @(posedge ref_clk);
    endtask : ph

    // data moves well after the fall so it never races the clock edge
    task automatic bit_io(input logic d, output logic b);
        repeat (2) @(posedge ref_clk);
        m_low <= ~d;
        ph();
        scl_clk <= 1'b1;
        ph();
        b = sda_w;
        scl_clk <= 1'b0;
    endtask : bit_io

    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ak, nak);
    endtask : xfer

    task automatic start;
        ph();
        m_low <= 1'b1;
        ph();
        scl_clk <= 1'b0;
    endtask : start

    task automatic stop;
        repeat (2) @(posedge ref_clk);
        m_low <= 1'b1;
        ph();
        scl_clk <= 1'b1;
        ph();
        m_low <= 1'b0;
        ph();
    endtask : stop

    // write frame: address, command and an optional data byte
    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic dv, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       n0;
        logic       n1;
        logic       n2;
        n2 = 1'b0;
        start();
        xfer({a, 1'b0}, 1'b1, q, n0);
        xfer(c, 1'b1, q, n1);
        if (dv)
            xfer(d, 1'b1, q, n2);
        stop();
        ok = !(n0 | n1 | n2);
    endtask : wr

    // read frame: two bytes, the last one refused to end the read
    task automatic rd(input logic [6:0] a, output logic [7:0] d0,
                      output logic [7:0] d1, output logic ok);
        logic [7:0] q;
        logic       n;
        start();
        xfer({a, 1'b1}, 1'b1, q, n);
        ok = !n;
        xfer(8'hff, 1'b0, d0, n);
        xfer(8'hff, 1'b1, d1, n);
        stop();
    endtask : rd
endmodule : iox_master

// file: bench/iox_top_bench.sv
`timescale 1ns/10ps
module iox_top_bench;
    import iox_pkg::*;

    // ***************************************************
    // signals
    // ***************************************************
    logic       ref_clk;
    logic       rst;
    logic       scl_clk;
    logic       m_low;
    logic       sda_oe;
    logic       sda_w;
    logic [2:0] strap;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_pu;
    logic       alert_oe;
    logic       sda_lvl;
    logic       alert_lvl;
    logic [6:0] dev;
    logic [7:0] d0;
    logic [7:0] d1;
    logic       ok;
    int         mismatches;
    int         checked;

    // open-drain data wire with its pull-up
    // the device pulls low only when it enables a low drive level
    assign sda_w = ~(m_low | (sda_oe & ~sda_lvl));

    initial
    begin
        ref_clk = 1'b0;
    end
    always #25 ref_clk = ~ref_clk;

    iox_top i_iox_top (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .scl_clk         (scl_clk),
        .sda_in          (sda_w),
        .sda_out         (sda_lvl),
        .sda_oe          (sda_oe),
        .addr_strap_bit0 (strap[0]),
        .addr_strap_bit1 (strap[1]),
        .addr_strap_bit2 (strap[2]),
        .port_pin_in     (pin_in),
        .port_pin_out    (pin_out),
        .port_pin_oe     (pin_oe),
        .port_pin_pullup (pin_pu),
        .alert_n_out     (alert_lvl),
        .alert_oe        (alert_oe)
    );

    iox_master i_iox_master (
        .ref_clk (ref_clk),
        .sda_w   (sda_w),
        .scl_clk (scl_clk),
        .m_low   (m_low)
    );

    // ***************************************************
    // helpers
    // ***************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // outputs are looked at mid-cycle, after the edge updates land
    task automatic settle;
        @(negedge ref_clk);
    endtask : settle

    task automatic chk(input logic [7:0] g, input logic [7:0] e,
                       input string m);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic wrr(input logic [7:0] c, input logic [7:0] d);
        i_iox_master.wr(dev, c, 1'b1, d, ok);
        chk({7'h0, ok}, 8'h01, "write ack");
    endtask : wrr

    // select, then read twice without a new command
    task automatic rdr(input logic [7:0] c, input logic [7:0] e);
        i_iox_master.wr(dev, c, 1'b0, 8'h00, ok);
        chk({7'h0, ok}, 8'h01, "select ack");
        i_iox_master.rd(dev, d0, d1, ok);
        chk({7'h0, ok}, 8'h01, "read ack");
        chk(d0, e, "first byte");
        chk(d1, e, "second byte");
    endtask : rdr

    // pins must stay undriven on each of the first eight cycles out of reset
    task automatic do_reset;
        cyc(1);
        rst <= 1'b1;
        cyc(16);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            settle();
            chk(pin_oe, 8'h00, "oe leaving reset");
            chk(pin_out, 8'hff, "out leaving reset");
        end
        cyc(4);
    endtask : do_reset

    // ***************************************************
    // tests
    // ***************************************************
    initial
    begin
        mismatches = 0;
        checked    = 0;
        rst        = 1'b1;
        strap      = 3'h5;
        pin_in     = 8'h00;
        dev        = {ADDR_PREFIX, 3'h5};
        do_reset();
        settle();
        chk(pin_pu, 8'hff, "pullup");
        chk({7'h0, alert_oe}, 8'h00, "alert idle");
        chk({7'h0, alert_lvl}, 8'h00, "alert level");
        chk({7'h0, sda_oe}, 8'h00, "bus idle");
        rdr(8'h03, 8'hff);
        rdr(8'h01, 8'hff);
        rdr(8'h02, 8'h00);
        $display("test defaults done");
        for (int s = 0; s < 8; s++)
        begin
            cyc(1);
            strap <= 3'(s);
            cyc(4);
            i_iox_master.wr({ADDR_PREFIX, 3'(s)}, 8'h03, 1'b0, 8'h00, ok);
            chk({7'h0, ok}, 8'h01, "own address");
            i_iox_master.wr({ADDR_PREFIX, ~3'(s)}, 8'h03, 1'b0, 8'h00, ok);
            chk({7'h0, ok}, 8'h00, "other address");
        end
        cyc(1);
        strap <= 3'h5;
        cyc(4);
        $display("test straps done");
        wrr(8'h03, 8'h0f);
        wrr(8'h01, 8'ha5);
        cyc(4);
        settle();
        chk(pin_oe, 8'hf0, "direction");
        chk(pin_pu, 8'h0f, "pullup split");
        chk(pin_out, 8'ha5, "levels");
        rdr(8'h01, 8'ha5);
        rdr(8'h03, 8'h0f);
        // a new frame with no command still reads the same register
        i_iox_master.rd(dev, d0, d1, ok);
        chk(d0, 8'h0f, "kept pointer");
        $display("test direction done");
        cyc(1);
        pin_in <= 8'h3c;
        cyc(6);
        rdr(8'h00, 8'h3c);
        wrr(8'hf2, 8'h81);
        rdr(8'h02, 8'h81);
        rdr(8'h00, 8'hbd);
        wrr(8'h00, 8'h55);
        rdr(8'h00, 8'hbd);
        settle();
        chk(pin_out, 8'ha5, "latched");
        $display("test input done");
        chk({7'h0, alert_oe}, 8'h00, "alert quiet");
        cyc(1);
        pin_in <= 8'h3e;
        cyc(6);
        settle();
        chk({7'h0, alert_oe}, 8'h01, "alert on");
        cyc(1);
        pin_in <= 8'h3c;
        cyc(6);
        settle();
        chk({7'h0, alert_oe}, 8'h00, "alert back");
        cyc(1);
        pin_in <= 8'h3d;
        cyc(6);
        settle();
        chk({7'h0, alert_oe}, 8'h01, "alert again");
        rdr(8'h00, 8'hbc);
        cyc(4);
        settle();
        chk({7'h0, alert_oe}, 8'h00, "alert read");
        $display("test alert done");
        cyc(1);
        pin_in <= 8'h00;
        do_reset();
        rdr(8'h03, 8'hff);
        rdr(8'h01, 8'hff);
        rdr(8'h02, 8'h00);
        $display("test second reset done");
        close_out();
    end

    // the tests take about 20000 cycles
    initial
    begin
        repeat (80000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
endmodule : iox_top_bench

// file: core/iox_link_shift.sv
`timescale 1ns/10ps
module iox_link_shift (
    // link clock
    input  wire logic       scl_clk,
    // serial data pin level
    input  wire logic       sda_in,
    // last eight bits seen, msb first
    output logic [7:0]      rx_byte
);

    // sample data on each rising clock edge; the word stays stable for a
    // whole bit period, and the other domain reads it in the cycle it sees
    // the synchronised clock edge, so it is read as qualified data
    always_ff @(posedge scl_clk)
    begin
        rx_byte <= {rx_byte[6:0], sda_in};
    end

endmodule : iox_link_shift

// file: core/iox_sync.sv
`timescale 1ns/10ps
module iox_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);

    logic [W-1:0] meta_ff;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule : iox_sync

// file: core/iox_top.sv
`timescale 1ns/10ps
module iox_top
    import iox_pkg::*;
(
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    // serial bus; the clock pin doubles as the link clock
    input  wire logic                           scl_clk,
    input  wire logic                           sda_in,
    output logic                                sda_out,
    output logic                                sda_oe,
    // address straps
    input  wire logic                           addr_strap_bit0,
    input  wire logic                           addr_strap_bit1,
    input  wire logic                           addr_strap_bit2,
    // port pins
    input  wire logic [iox_pkg::PORT_W-1:0]     port_pin_in,
    output logic      [iox_pkg::PORT_W-1:0]     port_pin_out,
    output logic      [iox_pkg::PORT_W-1:0]     port_pin_oe,
    output logic      [iox_pkg::PORT_W-1:0]     port_pin_pullup,
    // open-drain change alert, low when active
    output logic                                alert_n_out,
    output logic                                alert_oe
);

    import iox_pkg::*;

    // ***************************************************
    // synchronised pins and link word
    // ***************************************************
    logic                   scl_s;
    logic                   sda_s;
    logic [STRAP_W-1:0]     strap_s;
    logic [PORT_W-1:0]      pins_s;
    logic [7:0]             link_byte;
    logic                   scl_d_ff;
    logic                   sda_d_ff;

    // bus lines idle high, so they reset high to avoid a false edge
    iox_sync #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync_bus (
        .clk (ref_clk),
        .rst (rst),
        .d   ({scl_clk, sda_in}),
        .q   ({scl_s, sda_s})
    );

    iox_sync #(
        .W       (STRAP_W + PORT_W),
        .RST_VAL ('0)
    ) u_sync_pins (
        .clk (ref_clk),
        .rst (rst),
        .d   ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
               port_pin_in}),
        .q   ({strap_s, pins_s})
    );

    iox_link_shift u_link (
        .scl_clk (scl_clk),
        .sda_in  (sda_in),
        .rx_byte (link_byte)
    );

    // ***************************************************
    // bus events and engine state
    // ***************************************************
    iox_state_e             state_ff;
    logic [2:0]             bit_cnt_ff;
    logic                   rw_ff;
    logic                   sda_oe_ff;
    logic [7:0]             tx_ff;
    logic [1:0]             ptr_ff;
    logic                   cmd_pend_ff;
    logic [7:0]             out_ff;
    logic [7:0]             pol_ff;
    logic [7:0]             dir_ff;
    logic [7:0]             snap_ff;
    logic                   init_done_ff;
    logic                   alert_ff;
    logic [PORT_W-1:0]      pin_oe_ff;
    logic [PORT_W-1:0]      pin_out_ff;

    logic                   scl_rise;
    logic                   scl_fall;
    logic                   bus_start;
    logic                   bus_stop;
    logic                   counting;
    logic                   byte_done;
    logic                   addr_hit;
    logic                   ack_first;
    logic                   ack_done;
    logic                   cmd_en;
    logic                   wr_en;
    logic                   load_en;
    logic [7:0]             rd_data;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_d_ff <= 1'h1;
            sda_d_ff <= 1'h1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // edges seen on the synchronised lines, a few cycles late
    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign counting  = (state_ff == ST_ADDR) | (state_ff == ST_WR) |
                       (state_ff == ST_RD);
    assign byte_done = counting & scl_rise & (bit_cnt_ff == BIT_LAST);
    assign addr_hit  = (link_byte[7:1] == {ADDR_PREFIX, strap_s});
    assign ack_first = scl_fall & ~sda_oe_ff &
                       ((state_ff == ST_ACKA) | (state_ff == ST_ACKW));
    assign ack_done  = scl_fall & sda_oe_ff &
                       ((state_ff == ST_ACKA) | (state_ff == ST_ACKW));
    // first byte after the address is the command, the rest are data
    assign cmd_en    = byte_done & (state_ff == ST_WR) & cmd_pend_ff;
    assign wr_en     = byte_done & (state_ff == ST_WR) & ~cmd_pend_ff;
    assign load_en   = (ack_done & (state_ff == ST_ACKA) & rw_ff) |
                       (scl_fall & (state_ff == ST_RLOAD));

    // read data selection
    always_comb
    begin
        case (ptr_ff)
            REG_INPUT:  rd_data = pins_s ^ pol_ff;
            REG_OUTPUT: rd_data = out_ff;
            REG_POLAR:  rd_data = pol_ff;
            REG_DIR:    rd_data = dir_ff;
            default:    rd_data = pins_s;
        endcase
    end

    // ***************************************************
    // bus state machine
    // ***************************************************
    // start and stop win over everything, so a broken frame never hangs
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            rw_ff    <= 1'h0;
        end
        else if (bus_stop)
            state_ff <= ST_IDLE;
        else if (bus_start)
            state_ff <= ST_ADDR;
        else
        begin
            case (state_ff)
                ST_ADDR:
                    if (byte_done)
                    begin
                        state_ff <= addr_hit ? ST_ACKA : ST_IDLE;
                        rw_ff    <= link_byte[0];
                    end
                ST_ACKA:
                    if (ack_done)
                        state_ff <= (rw_ff == RW_READ) ? ST_RD : ST_WR;
                ST_WR:
                    if (byte_done)
                        state_ff <= ST_ACKW;
                ST_ACKW:
                    if (ack_done)
                        state_ff <= ST_WR;
                ST_RD:
                    if (byte_done)
                        state_ff <= ST_RACK;
                ST_RACK:
                    // master nack ends the read; wait for stop
                    if (scl_rise)
                        state_ff <= sda_s ? ST_IDLE : ST_RLOAD;
                ST_RLOAD:
                    if (scl_fall)
                        state_ff <= ST_RD;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // bit counter wraps to zero after each eighth bit
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bit_cnt_ff <= 3'h0;
        else if (bus_start || !counting)
            bit_cnt_ff <= 3'h0;
        else if (scl_rise)
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end

    // ***************************************************
    // serial data drive
    // ***************************************************
    // only ever pulls low for ack or read data while clock is low
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sda_oe_ff <= 1'h0;
            tx_ff     <= 8'h00;
        end
        else if (bus_stop || bus_start)
            sda_oe_ff <= 1'h0;
        else if (load_en)
        begin
            tx_ff     <= rd_data;
            sda_oe_ff <= ~rd_data[7];
        end
        else if (ack_first)
            sda_oe_ff <= 1'h1;
        else if (ack_done)
            sda_oe_ff <= 1'h0;
        else if (scl_fall && state_ff == ST_RD)
        begin
            tx_ff     <= {tx_ff[6:0], 1'h0};
            sda_oe_ff <= ~tx_ff[6];
        end
        else if (scl_fall && state_ff == ST_RACK)
            sda_oe_ff <= 1'h0;
    end

    assign sda_out = 1'h0;
    assign sda_oe  = sda_oe_ff;

    // ***************************************************
    // command pointer
    // ***************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ptr_ff      <= RST_PTR;
            cmd_pend_ff <= 1'h0;
        end
        else
        begin
            if (ack_done && state_ff == ST_ACKA && rw_ff != RW_READ)
                cmd_pend_ff <= 1'h1;
            else if (cmd_en || bus_stop)
                cmd_pend_ff <= 1'h0;
            // pointer is kept across frames until the next command
            if (cmd_en)
                ptr_ff <= link_byte[1:0];
        end
    end

    // ***************************************************
    // port registers
    // ***************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            out_ff <= RST_OUTPUT;
            pol_ff <= RST_POLAR;
            dir_ff <= RST_DIR;
        end
        else if (wr_en)
        begin
            // input register is read only; its writes fall through
            case (ptr_ff)
                REG_OUTPUT: out_ff <= link_byte;
                REG_POLAR:  pol_ff <= link_byte;
                REG_DIR:    dir_ff <= link_byte;
                default:    out_ff <= out_ff;
            endcase
        end
    end

    // pin drivers come from flops that reset undriven, so no glitch
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_oe_ff  <= '0;
            pin_out_ff <= RST_OUTPUT;
        end
        else
        begin
            pin_oe_ff  <= ~dir_ff;
            pin_out_ff <= out_ff;
        end
    end

    assign port_pin_oe     = pin_oe_ff;
    assign port_pin_out    = pin_out_ff;
    assign port_pin_pullup = ~pin_oe_ff;

    // ***************************************************
    // input register and change alert
    // ***************************************************
    // snapshot taken once after reset and on every input read
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            snap_ff      <= RST_SNAP;
            init_done_ff <= 1'h0;
        end
        else
        begin
            init_done_ff <= 1'h1;
            if (!init_done_ff || (load_en && ptr_ff == REG_INPUT))
                snap_ff <= pins_s;
        end
    end

    // only pins set as inputs can raise the alert
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            alert_ff <= 1'h0;
        else
            alert_ff <= init_done_ff &
                        (|((pins_s ^ snap_ff) & dir_ff));
    end

    assign alert_n_out = 1'h0;
    assign alert_oe    = alert_ff;

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_dir_write: assert property (
        (wr_en && ptr_ff == REG_DIR) |-> ##2
            (port_pin_oe == ~$past(link_byte, 2)))
        else $error("direction write did not reach pins");

    a_inputs_idle: assert property (
        (dir_ff == RST_DIR) [*2] |-> (port_pin_oe == '0))
        else $error("pin driven while all set as inputs");

    a_polarity_read: assert property (
        (load_en && ptr_ff == REG_INPUT) |=>
            (tx_ff == ($past(pins_s) ^ $past(pol_ff))))
        else $error("input read ignores polarity");

    a_alert_raise: assert property (
        (init_done_ff && |((pins_s ^ snap_ff) & dir_ff)) |=> alert_oe)
        else $error("alert missing on input change");

    a_alert_clear: assert property (
        (load_en && ptr_ff == REG_INPUT) ##1 $stable(pins_s)
            |=> !alert_oe)
        else $error("alert held after input read");

    a_input_ro: assert property (
        (wr_en && ptr_ff == REG_INPUT) |=>
            ($stable(out_ff) && $stable(pol_ff) && $stable(dir_ff)))
        else $error("write to input register changed state");

    a_output_hold: assert property (
        !wr_en |=> $stable(out_ff))
        else $error("output latch changed without write");

    a_slave_drive: assert property (
        sda_oe |-> (state_ff inside {ST_ACKA, ST_ACKW, ST_RD, ST_RACK,
                                     ST_RLOAD}))
        else $error("data line driven outside slave phases");

    a_addr_match: assert property (
        (state_ff == ST_ADDR && byte_done && addr_hit && !bus_stop &&
         !bus_start) |=> (state_ff == ST_ACKA && rw_ff == $past(link_byte[0])))
        else $error("own address not acknowledged");

    a_cmd_select: assert property (
        cmd_en |=> (ptr_ff == $past(link_byte[1:0])))
        else $error("command byte did not select register");

    a_ptr_kept: assert property (
        !cmd_en |=> $stable(ptr_ff))
        else $error("register pointer moved without command");

endmodule : iox_top

// file: pkg/iox_pkg.sv
package iox_pkg;

    // ***************************************************
    // port shape
    // ***************************************************
    localparam int         PORT_W      = 8;
    localparam int         STRAP_W     = 3;

    // ***************************************************
    // bus address and register selection
    // ***************************************************
    localparam logic [3:0] ADDR_PREFIX = 4'h4;
    localparam logic [1:0] REG_INPUT   = 2'h0;
    localparam logic [1:0] REG_OUTPUT  = 2'h1;
    localparam logic [1:0] REG_POLAR   = 2'h2;
    localparam logic [1:0] REG_DIR     = 2'h3;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic       RW_READ     = 1'h1;

    // ***************************************************
    // reset values
    // ***************************************************
    localparam logic [7:0] RST_OUTPUT  = 8'hff;
    localparam logic [7:0] RST_POLAR   = 8'h00;
    localparam logic [7:0] RST_DIR     = 8'hff;
    localparam logic [7:0] RST_SNAP    = 8'h00;
    localparam logic [1:0] RST_PTR     = 2'h0;

    // ***************************************************
    // bus engine states
    // ***************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACKA  = 3'b010,
        ST_WR    = 3'b011,
        ST_ACKW  = 3'b100,
        ST_RD    = 3'b101,
        ST_RACK  = 3'b110,
        ST_RLOAD = 3'b111
    } iox_state_e;

endpackage : iox_pkg
